// [rtl/fesf_flags.v]
// fesf_flags.v: program/erase error flags and status_two of a serial flash, wishbone slave
// assumes single clock, synchronous reset, classic wishbone master on the same clock
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`include "fesf_defines.vh"
module fesf_flags #(
    parameter AW = 32,
    parameter SW = 6
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         wb_err_o,
    output reg         busy_o,
    output reg         program_error_o,
    output reg         erase_error_o,
    output reg  [7:0]  status_two_o
);
    reg  [7:0]         protect_q;
    reg  [AW-1:0]      crc_start_q;
    reg  [AW-1:0]      crc_end_q;
    reg  [SW-1:0]      sector_q;
    reg                prg_err_q;
    reg                ers_err_q;
    reg  [4:0]         cfg_nv_q;
    reg                op_busy_q;

    wire               crc_run;
    wire               crc_susp;
    wire               crc_abort;
    wire               sect_ok;

    wire req    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire wr     = req & wb_we_i & wb_sel_i[0];
    wire wr_hi  = req & wb_we_i & wb_sel_i[1];
    wire [7:0]  d0 = wb_dat_i[7:0];
    wire [15:0] ev = {(wr_hi ? wb_dat_i[15:8] : 8'h00), (wr ? wb_dat_i[7:0] : 8'h00)};

    wire hit_s1  = wb_adr_i == `FESF_OFF_STATUS_ONE;
    wire hit_s2  = wb_adr_i == `FESF_OFF_STATUS_TWO;
    wire hit_ev  = wb_adr_i == `FESF_OFF_EVENT;
    wire hit_pr  = wb_adr_i == `FESF_OFF_PROTECT;
    wire hit_cs  = wb_adr_i == `FESF_OFF_CRC_START;
    wire hit_ce  = wb_adr_i == `FESF_OFF_CRC_END;
    wire hit_cc  = wb_adr_i == `FESF_OFF_CRC_CTRL;
    wire hit_sc  = wb_adr_i == `FESF_OFF_SECTOR;
    wire hit_cm  = wb_adr_i == `FESF_OFF_COMMAND;
    wire mapped  = hit_s1 | hit_s2 | hit_ev | hit_pr | hit_cs | hit_ce | hit_cc | hit_sc | hit_cm;

    wire err_any   = prg_err_q | ers_err_q;
    wire busy_now  = err_any | op_busy_q | crc_run;
    // error state refuses new operation events, busy does not; clear and reset stay open
    wire accept    = ~err_any;
    wire ev_wr     = hit_ev & accept;
    wire [15:0] evq = ev_wr ? ev : 16'h0000;

    wire cmd_clear = hit_cm & wr & d0[`FESF_CMD_CLEAR_FAIL];
    wire cmd_reset = hit_cm & wr & d0[`FESF_CMD_SOFT_RESET];
    wire cmd_eval  = hit_cm & wr & d0[`FESF_CMD_EVAL_ERASE] & accept;
    wire cc_wr     = hit_cc & wr & accept;

    // a nonvolatile config write carries its new bits 6:2 in event data 15:11
    wire cfg_locked = ~protect_q[`FESF_PR_ASP2] | ~protect_q[`FESF_PR_ASP1];
    wire nv_write   = evq[`FESF_EV_NVREG_WRITE];
    wire [4:0] nv_data = wb_dat_i[15:11];
    wire nv_change  = nv_write & wr_hi & (nv_data != cfg_nv_q);

    wire prg_set = evq[`FESF_EV_PRG_NO_CHANGE]
                 | evq[`FESF_EV_PRG_PROT]
                 | (nv_change & cfg_locked)
                 | (evq[`FESF_EV_PWD_UPDATE] & protect_q[`FESF_PR_PWD_MODE])
                 | evq[`FESF_EV_BOOT_FAIL] | evq[`FESF_EV_CFG_FAIL];
    wire ers_set = evq[`FESF_EV_ERS_FAIL]
                 | evq[`FESF_EV_ERS_PROT]
                 | evq[`FESF_EV_NVREG_ERS_FAIL]
                 | evq[`FESF_EV_BOOT_FAIL];

    wire sect_done = evq[`FESF_EV_SECT_ERASE];

    fesf_crc_ctl #(
        .AW (AW)
    ) u_crc (
        .clk_i        (clk_i),
        .rst_i        (rst_i | (cmd_reset & ce_i)),
        .ce_i         (ce_i),
        .start_addr_i (crc_start_q),
        .end_addr_i   (crc_end_q),
        .start_i      (cc_wr & d0[`FESF_CC_START]),
        .suspend_i    (cc_wr & d0[`FESF_CC_SUSPEND]),
        .resume_i     (cc_wr & d0[`FESF_CC_RESUME]),
        .done_i       (cc_wr & d0[`FESF_CC_DONE]),
        .running_o    (crc_run),
        .suspended_o  (crc_susp),
        .aborted_o    (crc_abort)
    );

    fesf_sector_track #(
        .SW (SW)
    ) u_sect (
        .clk_i          (clk_i),
        // soft reset must not slip past a frozen clock enable
        .rst_i          (rst_i | (cmd_reset & ce_i)),
        .ce_i           (ce_i),
        .erase_sector_i (sector_q),
        .erase_done_i   (sect_done),
        .erase_ok_i     (ev[`FESF_EV_SECT_ERASE_OK] & ~ers_set),
        .eval_sector_i  (sector_q),
        .eval_i         (cmd_eval),
        .sector_ok_o    (sect_ok)
    );

    // error flags: set beats clear in the same cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            prg_err_q <= 1'b0;
            ers_err_q <= 1'b0;
        end else if (ce_i) begin
            if (prg_set) begin
                prg_err_q <= 1'b1;
            end else if (cmd_clear | cmd_reset) begin
                prg_err_q <= 1'b0;
            end
            if (ers_set) begin
                ers_err_q <= 1'b1;
            end else if (cmd_clear | cmd_reset) begin
                ers_err_q <= 1'b0;
            end
        end
    end

    // configuration and address registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            protect_q   <= `FESF_PR_RESET;
            crc_start_q <= {AW{1'b0}};
            crc_end_q   <= {AW{1'b0}};
            sector_q    <= {SW{1'b0}};
            cfg_nv_q    <= 5'h00;
            op_busy_q   <= 1'b0;
        end else if (ce_i) begin
            if (hit_pr & wr) begin
                protect_q <= d0;
            end
            if (hit_cs & req & wb_we_i) begin
                crc_start_q <= wb_dat_i[AW-1:0];
            end
            if (hit_ce & req & wb_we_i) begin
                crc_end_q <= wb_dat_i[AW-1:0];
            end
            if (hit_sc & wr) begin
                sector_q <= wb_dat_i[SW-1:0];
            end
            if (nv_change & ~cfg_locked & ~prg_set) begin
                cfg_nv_q <= nv_data;
            end
            // one cycle of busy for each accepted operation event
            op_busy_q <= |evq | cmd_eval;
        end
    end

    // wishbone answer: one cycle after the request, dropped the cycle after
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= req & mapped;
            wb_err_o <= req & ~mapped;
            wb_dat_o <= 32'h0000_0000;
            if (req & ~wb_we_i) begin
                if (hit_s1) begin
                    wb_dat_o[`FESF_S1_BUSY]    <= busy_now;
                    wb_dat_o[`FESF_S1_ERS_ERR] <= ers_err_q;
                    wb_dat_o[`FESF_S1_PRG_ERR] <= prg_err_q;
                end else if (hit_s2) begin
                    wb_dat_o[7:0] <= status_two_o;
                end else if (hit_pr) begin
                    wb_dat_o[7:0] <= protect_q;
                end else if (hit_cs) begin
                    wb_dat_o[AW-1:0] <= crc_start_q;
                end else if (hit_ce) begin
                    wb_dat_o[AW-1:0] <= crc_end_q;
                end else if (hit_sc) begin
                    wb_dat_o[SW-1:0] <= sector_q;
                end else if (hit_ev) begin
                    wb_dat_o[15:11] <= cfg_nv_q;
                end
            end
        end
    end

    // pin-level status outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            busy_o          <= 1'b0;
            program_error_o <= 1'b0;
            erase_error_o   <= 1'b0;
            status_two_o    <= `FESF_STATUS_RESET;
        end else if (ce_i) begin
            busy_o          <= busy_now;
            program_error_o <= prg_err_q;
            erase_error_o   <= ers_err_q;
            // reserved bits 7:5 and suspend bits 1:0 read zero here
            status_two_o    <= {3'b000, crc_susp, crc_abort, sect_ok, 2'b00};
        end
    end
endmodule // fesf_flags

// [rtl/fesf_defines.vh]
// fesf_defines.vh: offsets, field positions, reset values and counts of the flag block
// assumes inclusion by bare name from the rtl files
`ifndef FESF_DEFINES_VH
`define FESF_DEFINES_VH

// register word offsets (byte addresses, 32-bit words)
`define FESF_OFF_STATUS_ONE   8'h00
`define FESF_OFF_STATUS_TWO   8'h04
`define FESF_OFF_EVENT        8'h08
`define FESF_OFF_PROTECT      8'h0C
`define FESF_OFF_CRC_START    8'h10
`define FESF_OFF_CRC_END      8'h14
`define FESF_OFF_CRC_CTRL     8'h18
`define FESF_OFF_SECTOR       8'h1C
`define FESF_OFF_COMMAND      8'h20

// status_one field positions
`define FESF_S1_BUSY          0
`define FESF_S1_ERS_ERR       5
`define FESF_S1_PRG_ERR       6

// status_two field positions
`define FESF_S2_SECT_OK       2
`define FESF_S2_CRC_ABORT     3
`define FESF_S2_CRC_SUSP      4

// event register bits (write one to raise the event)
`define FESF_EV_PRG_NO_CHANGE 0
`define FESF_EV_PRG_PROT      1
`define FESF_EV_NVREG_WRITE   2
`define FESF_EV_PWD_UPDATE    3
`define FESF_EV_BOOT_FAIL     4
`define FESF_EV_CFG_FAIL      5
`define FESF_EV_ERS_FAIL      6
`define FESF_EV_ERS_PROT      7
`define FESF_EV_NVREG_ERS_FAIL 8
`define FESF_EV_SECT_ERASE    9
`define FESF_EV_SECT_ERASE_OK 10
`define FESF_EV_WIDTH         11

// protect register bits
`define FESF_PR_ASP1          0
`define FESF_PR_ASP2          1
`define FESF_PR_PWD_MODE      2
`define FESF_PR_CFG_LO        3
`define FESF_PR_CFG_HI        7
`define FESF_PR_RESET         8'h06

// crc control bits
`define FESF_CC_START         0
`define FESF_CC_SUSPEND       1
`define FESF_CC_RESUME        2
`define FESF_CC_DONE          3

// command register bits
`define FESF_CMD_CLEAR_FAIL   0
`define FESF_CMD_SOFT_RESET   1
`define FESF_CMD_EVAL_ERASE   2

`define FESF_CRC_MIN_SPAN     32'h0000_0003
`define FESF_STATUS_RESET     8'h00
`define FESF_ADDR_W           8

`endif

// [rtl/fesf_crc_ctl.v]
// fesf_crc_ctl.v: array integrity check sequencer, suspend and abort flags
// assumes start, suspend, resume and done pulses on clk_i
`timescale 1ns/10ps
`include "fesf_defines.vh"
module fesf_crc_ctl #(
    parameter AW = 32
) (
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire          ce_i,
    input  wire [AW-1:0] start_addr_i,
    input  wire [AW-1:0] end_addr_i,
    input  wire          start_i,
    input  wire          suspend_i,
    input  wire          resume_i,
    input  wire          done_i,
    output reg           running_o,
    output reg           suspended_o,
    output reg           aborted_o
);
    localparam IDLE = 2'b00;
    localparam RUN  = 2'b01;
    localparam SUSP = 2'b10;

    reg  [1:0]  state_q;
    wire [AW:0] limit = {1'b0, start_addr_i} + `FESF_CRC_MIN_SPAN;
    wire        too_short = {1'b0, end_addr_i} < limit;

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q     <= IDLE;
            running_o   <= 1'b0;
            suspended_o <= 1'b0;
            aborted_o   <= 1'b0;
        end else if (ce_i) begin
            case (state_q)
                IDLE: begin
                    if (start_i) begin
                        if (too_short) begin
                            aborted_o <= 1'b1;
                        end else begin
                            aborted_o <= 1'b0;
                            state_q   <= RUN;
                            running_o <= 1'b1;
                        end
                    end
                end
                RUN: begin
                    if (done_i) begin
                        state_q   <= IDLE;
                        running_o <= 1'b0;
                    end else if (suspend_i) begin
                        state_q     <= SUSP;
                        suspended_o <= 1'b1;
                    end
                end
                SUSP: begin
                    if (resume_i) begin
                        state_q     <= RUN;
                        suspended_o <= 1'b0;
                    end
                end
                default: begin
                    state_q     <= IDLE;
                    running_o   <= 1'b0;
                    suspended_o <= 1'b0;
                end
            endcase
        end
    end
endmodule // fesf_crc_ctl

// [rtl/fesf_sector_track.v]
// fesf_sector_track.v: remembers per-sector erase outcome, answers evaluate requests
// assumes sector index already reduced to SW bits
`timescale 1ns/10ps
module fesf_sector_track #(
    parameter SW = 6
) (
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire          ce_i,
    input  wire [SW-1:0] erase_sector_i,
    input  wire          erase_done_i,
    input  wire          erase_ok_i,
    input  wire [SW-1:0] eval_sector_i,
    input  wire          eval_i,
    output reg           sector_ok_o
);
    reg [(1<<SW)-1:0] ok_q;

    // erased flash keeps its outcome across resets in silicon; here reset clears it
    genvar g;
    generate
        for (g = 0; g < (1<<SW); g = g + 1) begin : g_sect
            always @(posedge clk_i) begin
                if (rst_i) begin
                    ok_q[g] <= 1'b0;
                end else if (ce_i && erase_done_i && erase_sector_i == g) begin
                    ok_q[g] <= erase_ok_i;
                end
            end
        end
    endgenerate

    always @(posedge clk_i) begin
        if (rst_i) begin
            sector_ok_o <= 1'b0;
        end else if (ce_i && eval_i) begin
            sector_ok_o <= ok_q[eval_sector_i];
        end
    end
endmodule // fesf_sector_track

// [testbench/fesf_host.sv]
// fesf_host.sv: host-side model, classic wishbone master with flag-reading helpers
// assumes one clock shared with the slave, requests taken on rising edges
`timescale 1ns/10ps
module fesf_host (
    input  wire         clk_i,
    input  wire         ack_i,
    input  wire         err_i,
    input  wire  [31:0] dat_i,
    output logic        cyc_o,
    output logic        stb_o,
    output logic        we_o,
    output logic [7:0]  adr_o,
    output logic [3:0]  sel_o,
    output logic [31:0] dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0000_0000;
    end

    // request held until ack or err is sampled high, then released
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        sel_o <= 4'hf;
        dat_o <= d;
        do @(posedge clk_i); while (!(ack_i || err_i));
        q = dat_i;
        e = err_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // released address and data lines show no stale value
        adr_o <= ~a;
        dat_o <= ~d;
    endtask

    // never writes status_two, reserved bits stay at default
    task automatic sector_ok(input logic [31:0] s, output logic [31:0] v);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, 8'h1C, s, q, e);
        xfer(1'b1, 8'h20, 32'h0000_0004, q, e);
        do xfer(1'b0, 8'h00, 32'h0000_0000, q, e); while (q[0] !== 1'b0);
        xfer(1'b0, 8'h04, 32'h0000_0000, v, e);
    endtask
endmodule // fesf_host

// [testbench/fesf_flags_sva.sv]
// fesf_flags_sva.sv: port-level checker for the flag block
// assumes it is bound into fesf_flags and sees only its ports
`timescale 1ns/10ps
module fesf_flags_chk #(
    parameter AW = 32,
    parameter SW = 6
) (
    input wire        clk_i,
    input wire        rst_i,
    input wire        ce_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        wb_err_o,
    input wire        busy_o,
    input wire        program_error_o,
    input wire        erase_error_o,
    input wire [7:0]  status_two_o
);
    wire req_w  = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && ce_i;
    wire wr_w   = req_w && wb_we_i;
    wire ev_w   = wr_w && wb_adr_i == 8'h08;
    wire crc_w  = wr_w && wb_adr_i == 8'h18;
    wire cmd_w  = wr_w && wb_adr_i == 8'h20 && wb_dat_i[1:0] != 2'h0;
    wire eval_w = wr_w && wb_adr_i == 8'h20 && wb_dat_i[2:1] != 2'h0;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // pins lag the taking edge by two to four cycles
    sequence s_took(x);
        $past(x, 2) || $past(x, 3) || $past(x, 4);
    endsequence

    AST_ACK_ONE: assert property (req_w |=> wb_ack_o ^ wb_err_o)
        else $error("request not answered in one cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data without ack");
    AST_RSV_ZERO: assert property (status_two_o[7:5] == 3'h0 && status_two_o[1:0] == 2'h0)
        else $error("status_two reserved bits set");
    AST_PRG_SET: assert property ($rose(program_error_o) |-> s_took(ev_w))
        else $error("program error rose without event");
    AST_ERS_SET: assert property ($rose(erase_error_o) |-> s_took(ev_w))
        else $error("erase error rose without event");
    AST_PRG_HOLD: assert property ($fell(program_error_o) |-> s_took(cmd_w))
        else $error("program error cleared without command");
    AST_BUSY: assert property ($rose(program_error_o || erase_error_o) |-> busy_o [*2])
        else $error("busy low while error flag set");
    AST_SUSP: assert property ($changed(status_two_o[4]) |-> s_took(crc_w || cmd_w))
        else $error("suspend flag moved without request");
    AST_ABORT: assert property ($rose(status_two_o[3]) |-> s_took(crc_w))
        else $error("abort flag rose without start");
    AST_ABORT_CLR: assert property ($fell(status_two_o[3]) |-> s_took(crc_w || cmd_w))
        else $error("abort flag fell without start");
    AST_SECT: assert property ($changed(status_two_o[2]) |-> s_took(eval_w))
        else $error("sector flag moved without evaluate");
endmodule // fesf_flags_chk

bind fesf_flags fesf_flags_chk #(.AW(AW), .SW(SW)) i_fesf_flags_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .busy_o(busy_o),
    .program_error_o(program_error_o), .erase_error_o(erase_error_o),
    .status_two_o(status_two_o));

// [testbench/fesf_flags_tb_top.sv]
// fesf_flags_tb_top.sv: directed register-level tests of the flag block
// assumes host model fesf_host and the bound checker are compiled alongside
`timescale 1ns/10ps
module fesf_flags_tb_top;
    logic        clk_i, rst_i, ce_i, e;
    wire         cyc, stb, we, ack, err, busy, perr, eerr;
    wire  [7:0]  adr, s2;
    wire  [3:0]  sel;
    wire  [31:0] wdat, rdat;
    logic [31:0] q;
    int          n_errors = 0, n_compared = 0, cycles = 0, i;
    // event word and expected status_one for each error source
    logic [31:0] ev [0:8] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_F804, 32'h0000_0008,
        32'h0000_0010, 32'h0000_0020, 32'h0000_0040, 32'h0000_0080, 32'h0000_0100};
    logic [7:0]  st [0:8] = '{8'h41, 8'h41, 8'h41, 8'h41, 8'h61, 8'h41, 8'h21, 8'h21, 8'h21};

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    fesf_flags i_fesf_flags (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .busy_o(busy),
        .program_error_o(perr), .erase_error_o(eerr), .status_two_o(s2));
    fesf_host i_fesf_host (.clk_i(clk_i), .ack_i(ack), .err_i(err), .dat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_fesf_host.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        i_fesf_host.xfer(1'b0, a, 32'h0000_0000, q, e);
        chk(nm, exp, q);
    endtask
    task automatic finish_test;
        if (n_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // a hang is cut short well past the expected run length
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            finish_test;
        end
    end

    initial begin
        rst_i = 1'b1;
        ce_i  = 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("status_one", 8'h00, 32'h0000_0000);
        rd("status_two", 8'h04, 32'h0000_0000);
        rd("protect", 8'h0C, 32'h0000_0006);
        i_fesf_host.xfer(1'b0, 8'h40, 32'h0000_0000, q, e);
        chk("unmapped err", 32'h0000_0001, {31'h0000_0000, e});
        for (i = 0; i < 9; i++) begin
            wr(8'h08, ev[i]);
            rd("status_one err", 8'h00, {24'h00_0000, st[i]});
            chk("error pins", {30'h0000_0000, st[i][6:5]}, {30'h0000_0000, perr, eerr});
            wr(8'h20, 32'h0000_0001);
            rd("status_one clear", 8'h00, 32'h0000_0000);
        end
        // protect bits set and password mode off: same requests are harmless
        wr(8'h0C, 32'h0000_0003);
        wr(8'h08, 32'h0000_0804);
        wr(8'h08, 32'h0000_0008);
        rd("status_one allowed", 8'h00, 32'h0000_0000);
        rd("cfg readback", 8'h08, 32'h0000_0800);
        // error holds and check start is refused while it stands
        wr(8'h08, 32'h0000_0001);
        wr(8'h10, 32'h0000_0100);
        wr(8'h14, 32'h0000_0101);
        wr(8'h18, 32'h0000_0001);
        wr(8'h08, 32'h0000_0000);
        rd("status_one hold", 8'h00, 32'h0000_0041);
        rd("crc start", 8'h10, 32'h0000_0100);
        rd("crc end", 8'h14, 32'h0000_0101);
        wr(8'h20, 32'h0000_0001);
        rd("status_two refused", 8'h04, 32'h0000_0000);
        wr(8'h14, 32'h0000_0102);
        wr(8'h18, 32'h0000_0001);
        rd("status_two abort", 8'h04, 32'h0000_0008);
        rd("status_one idle", 8'h00, 32'h0000_0000);
        wr(8'h14, 32'h0000_0103);
        wr(8'h18, 32'h0000_0001);
        rd("status_two restart", 8'h04, 32'h0000_0000);
        rd("status_one running", 8'h00, 32'h0000_0001);
        chk("busy pin", 32'h0000_0001, {31'h0000_0000, busy});
        wr(8'h18, 32'h0000_0002);
        rd("status_two suspend", 8'h04, 32'h0000_0010);
        chk("status_two pin", 32'h0000_0010, {24'h00_0000, s2});
        wr(8'h18, 32'h0000_0004);
        rd("status_two resume", 8'h04, 32'h0000_0000);
        wr(8'h18, 32'h0000_0008);
        rd("status_one done", 8'h00, 32'h0000_0000);
        wr(8'h1C, 32'h0000_0005);
        wr(8'h08, 32'h0000_0600);
        wr(8'h1C, 32'h0000_0006);
        wr(8'h08, 32'h0000_0200);
        i_fesf_host.sector_ok(32'h0000_0005, q);
        chk("sector ok", 32'h0000_0004, q);
        i_fesf_host.sector_ok(32'h0000_0006, q);
        chk("sector failed", 32'h0000_0000, q);
        rd("sector index", 8'h1C, 32'h0000_0006);
        // frozen clock enable holds the error flag and delays the clear
        wr(8'h08, 32'h0000_0001);
        ce_i <= 1'b0;
        fork
            wr(8'h20, 32'h0000_0001);
            begin
                repeat (4) @(posedge clk_i);
                chk("frozen error pin", 32'h0000_0001, {31'h0000_0000, perr});
                ce_i <= 1'b1;
            end
        join
        rd("status_one thawed", 8'h00, 32'h0000_0000);
        wr(8'h08, 32'h0000_0001);
        wr(8'h20, 32'h0000_0002);
        rd("status_one soft reset", 8'h00, 32'h0000_0000);
        i_fesf_host.sector_ok(32'h0000_0005, q);
        chk("sector after reset", 32'h0000_0000, q);
        finish_test;
    end
endmodule // fesf_flags_tb_top
